// *** ccs_pkg.sv ***
// Purpose: shared constants for the charger control sequencer
// Assumes: 200 MHz system clock
// Notes: times kept in their own units, cycle counts derived
package ccs_pkg;
  // ==========================================================
  // timing
  localparam longint CLK_HZ = 200000000;
  localparam longint QUAL_MS = 30;
  localparam longint RETRY_MS = 2000;
  localparam longint BOOST_S = 32;
  localparam longint CHARGE_MIN = 32;
  localparam longint QUAL_CYC = QUAL_MS * CLK_HZ / 1000;
  localparam longint RETRY_CYC = RETRY_MS * CLK_HZ / 1000;
  localparam longint BOOST_CYC = BOOST_S * CLK_HZ;
  localparam longint CHARGE_CYC = CHARGE_MIN * 60 * CLK_HZ;
  localparam int TMR_W = 40;
  // ==========================================================
  // operation select encodings
  localparam logic [1:0] OP_OFF = 2'h0;
  localparam logic [1:0] OP_BOOST = 2'h1;
  localparam logic [1:0] OP_CHG = 2'h2;
  localparam logic [1:0] OP_CHG_TERM = 2'h3;
  // ==========================================================
  // second fault flag register field positions
  localparam int FLG_BAD_ADAPTOR = 0;
  localparam int FLG_CHARGE_TO = 1;
  localparam int FLG_BOOST_TO = 2;
  localparam int FLG_FAULT = 3;
  localparam int FLG_W = 4;
  // ==========================================================
  // reset values
  localparam logic [1:0] INPUT_LIMIT_RST = 2'h0; // 100 mA setting
  localparam logic TERM_EN_RST = 1'b0;
  // ==========================================================
  // charger states
  typedef enum logic [2:0] {
    ST_HIZ = 3'b000,
    ST_QUAL = 3'b001,
    ST_RETRY = 3'b010,
    ST_PRECHG = 3'b011,
    ST_FAST = 3'b100,
    ST_DONE = 3'b101
  } ccs_state_type;
endpackage

// *** ccs_sequencer.sv ***
// Purpose: digital control sequencer of a single-cell charger
// Assumes: analog comparator outputs arrive asynchronously
// Notes: host register writes appear as strobes from an i2c slave
//
// Function
// [R1] sink on, adaptor good after 30 ms
// [R2] input drop: sink off, flag, interrupt
// [R3] bad adaptor: wait 2 s, retest
// [R4] sink active one 30 ms window only
// [R5] input valid sets low charge limit bit
// [R6] below precharge threshold use short current
// [R7] terminate at termination current when enabled
// [R8] termination disabled after reset, host enables
// [R9] four events restart the charge cycle
// [R10] over-temperature forces high impedance, then resume
// [R11] timer runs when op nonzero, i2c restarts
// [R12] boost 32 s expiry clears op, flags
// [R13] charge 32 min expiry clears op, flags
// [R14] expiry touches only operation select
// [R15] synchronous above 100 mA, else non-synchronous
// [R16] input current limit defaults to 100 mA
// [R17] regulation voltage host programmable
// [R18] charging fault: clear op, flag, high impedance
// [R19] flags cleared by read, no repeat interrupt
// [R20] timer held zero while op off
module ccs_sequencer #(
  parameter longint QUAL_CYC = ccs_pkg::QUAL_CYC,
  parameter longint RETRY_CYC = ccs_pkg::RETRY_CYC,
  parameter longint BOOST_CYC = ccs_pkg::BOOST_CYC,
  parameter longint CHARGE_CYC = ccs_pkg::CHARGE_CYC,
  parameter int VREG_W = 6,
  parameter int ICHG_W = 4
) (
  input wire logic clk,
  input wire logic nrst,
  // asynchronous analog indications
  input wire logic input_valid,
  input wire logic input_above_min,
  input wire logic bat_below_precharge,
  input wire logic bat_below_recharge,
  input wire logic at_termination_current,
  input wire logic in_voltage_regulation,
  input wire logic over_temperature,
  input wire logic low_side_above_100ma,
  input wire logic charge_fault,
  // host side, same clock as the i2c slave
  input wire logic i2c_valid_cmd,
  input wire logic op_wr,
  input wire logic [1:0] op_wdata,
  input wire logic cfg_wr,
  input wire logic term_en_wdata,
  input wire logic low_charge_limit_bit_wdata,
  input wire logic [1:0] input_limit_wdata,
  input wire logic [VREG_W-1:0] vreg_wdata,
  input wire logic [ICHG_W-1:0] ichg_wdata,
  input wire logic host_reset_bit,
  input wire logic flag_rd,
  // outputs
  output logic [1:0] operation_select,
  output logic termination_enable,
  output logic low_charge_limit_bit,
  output logic [1:0] input_current_limit,
  output logic [VREG_W-1:0] regulation_voltage,
  output logic [ICHG_W-1:0] fast_charge_current,
  output logic [ccs_pkg::FLG_W-1:0] second_fault_flag_register,
  output logic irq_pulse,
  output logic qual_sink_on,
  output logic short_circuit_current,
  output logic fast_charging,
  output logic charging,
  output logic charge_done,
  output logic high_impedance_state,
  output logic boost_on,
  output logic low_side_switch_sync
);
  // ==========================================================
  // input synchronisers
  localparam int NS = 9;
  logic [NS-1:0] raw;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  assign raw = {input_valid, input_above_min, bat_below_precharge,
                bat_below_recharge, at_termination_current,
                in_voltage_regulation, over_temperature,
                low_side_above_100ma, charge_fault};
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic vin_ok, minimum_input_threshold, below_pre, below_rech, at_term, in_cv;
  logic hot, ls_high, fault;
  assign {vin_ok, minimum_input_threshold, below_pre, below_rech, at_term, in_cv,
          hot, ls_high, fault} = s2_q;

  // ==========================================================
  // state
  ccs_pkg::ccs_state_type st_q, st_d;
  logic [ccs_pkg::TMR_W-1:0] cnt_q, cnt_d;
  logic [ccs_pkg::TMR_W-1:0] tmr_q, tmr_d;
  logic [1:0] op_q, op_d;
  logic term_q, term_d;
  logic lowchg_q, lowchg_d;
  logic [1:0] ilim_q, ilim_d;
  logic [VREG_W-1:0] vreg_q, vreg_d;
  logic [ICHG_W-1:0] ichg_q, ichg_d;
  logic [ccs_pkg::FLG_W-1:0] flg_q, flg_d;
  logic vin_ok_q, irq_q, irq_d;
  logic charge_op, restart, vin_rise, fault_q, fault_d;
  // limits trimmed to the counter width on purpose
  localparam int TW = ccs_pkg::TMR_W;
  localparam longint QUAL_END = QUAL_CYC - 1;
  localparam longint RETRY_END = RETRY_CYC - 1;
  localparam logic [TW-1:0] QUAL_LIM = QUAL_END[TW-1:0];
  localparam logic [TW-1:0] RETRY_LIM = RETRY_END[TW-1:0];
  localparam logic [TW-1:0] BOOST_LIM = BOOST_CYC[TW-1:0];
  localparam logic [TW-1:0] CHARGE_LIM = CHARGE_CYC[TW-1:0];

  assign charge_op = (op_q == ccs_pkg::OP_CHG) ||
                     (op_q == ccs_pkg::OP_CHG_TERM);
  assign vin_rise = vin_ok && !vin_ok_q;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    tmr_d = tmr_q;
    op_d = op_q;
    term_d = term_q;
    lowchg_d = lowchg_q;
    ilim_d = ilim_q;
    vreg_d = vreg_q;
    ichg_d = ichg_q;
    flg_d = flg_q;
    irq_d = 1'b0;
    fault_d = fault;
    restart = 1'b0;
    // host writes
    if (op_wr) begin
      op_d = op_wdata;
    end
    if (cfg_wr) begin
      term_d = term_en_wdata; // see [R8]
      lowchg_d = low_charge_limit_bit_wdata; // see [R5]
      ilim_d = input_limit_wdata; // see [R16]
      vreg_d = vreg_wdata; // see [R17]
      ichg_d = ichg_wdata; // see [R16]
    end
    if (vin_rise) begin
      lowchg_d = 1'b1; // see [R5]
    end
    // flags cleared by read, a same-cycle set wins below
    if (flag_rd) begin
      flg_d = '0; // see [R19]
    end
    // restart events
    if (vin_rise || host_reset_bit) begin
      restart = 1'b1; // see [R9]
    end
    if (op_q == ccs_pkg::OP_CHG_TERM && term_q && below_rech &&
        st_q == ccs_pkg::ST_DONE) begin
      restart = 1'b1; // see [R9]
    end
    if (st_q == ccs_pkg::ST_DONE && term_q && cfg_wr && !term_en_wdata) begin
      restart = 1'b1; // see [R9]
    end
    // safety timer
    if (op_q == ccs_pkg::OP_OFF) begin
      tmr_d = '0; // see [R20]
    end else if (i2c_valid_cmd) begin
      tmr_d = '0; // see [R11]
    end else begin
      tmr_d = tmr_q + 1'b1; // see [R11]
    end
    if (op_q == ccs_pkg::OP_BOOST &&
        tmr_q >= BOOST_LIM) begin
      op_d = ccs_pkg::OP_OFF; // see [R12] [R14]
      tmr_d = '0;
      flg_d[ccs_pkg::FLG_BOOST_TO] = 1'b1;
      irq_d = 1'b1;
    end
    if (charge_op && tmr_q >= CHARGE_LIM) begin
      op_d = ccs_pkg::OP_OFF; // see [R13] [R14]
      tmr_d = '0;
      flg_d[ccs_pkg::FLG_CHARGE_TO] = 1'b1;
      irq_d = 1'b1;
    end
    // charge faults, only a new fault interrupts
    if (fault && charge_op && st_q != ccs_pkg::ST_HIZ) begin
      op_d = ccs_pkg::OP_OFF; // see [R18]
      flg_d[ccs_pkg::FLG_FAULT] = 1'b1;
      st_d = ccs_pkg::ST_HIZ;
      if (!fault_q) begin
        irq_d = 1'b1; // see [R19]
      end
    end else if (!charge_op || !vin_ok || hot) begin
      st_d = ccs_pkg::ST_HIZ; // see [R10]
      cnt_d = '0;
    end else if (restart && st_q != ccs_pkg::ST_QUAL) begin
      st_d = ccs_pkg::ST_QUAL; // see [R9]
      cnt_d = '0;
    end else begin
      unique case (st_q)
        ccs_pkg::ST_HIZ: begin
          st_d = ccs_pkg::ST_QUAL; // see [R10]
          cnt_d = '0;
        end
        ccs_pkg::ST_QUAL: begin
          if (!minimum_input_threshold) begin
            st_d = ccs_pkg::ST_RETRY; // see [R2]
            cnt_d = '0;
            flg_d[ccs_pkg::FLG_BAD_ADAPTOR] = 1'b1;
            irq_d = 1'b1;
          end else if (cnt_q >= QUAL_LIM) begin
            st_d = ccs_pkg::ST_PRECHG; // see [R1] [R4]
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        ccs_pkg::ST_RETRY: begin
          if (cnt_q >= RETRY_LIM) begin
            st_d = ccs_pkg::ST_QUAL; // see [R3]
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        ccs_pkg::ST_PRECHG: begin
          if (!below_pre) begin
            st_d = ccs_pkg::ST_FAST; // see [R6]
          end
        end
        ccs_pkg::ST_FAST: begin
          if (below_pre) begin
            st_d = ccs_pkg::ST_PRECHG; // see [R6]
          end else if (in_cv && at_term && term_q && !below_rech) begin
            st_d = ccs_pkg::ST_DONE; // see [R7]
          end
        end
        ccs_pkg::ST_DONE: begin
          st_d = ccs_pkg::ST_DONE;
        end
        default: begin
          st_d = ccs_pkg::ST_HIZ;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= ccs_pkg::ST_HIZ;
      cnt_q <= '0;
      tmr_q <= '0;
      op_q <= ccs_pkg::OP_OFF;
      term_q <= ccs_pkg::TERM_EN_RST; // see [R8]
      lowchg_q <= 1'b0;
      ilim_q <= ccs_pkg::INPUT_LIMIT_RST; // see [R16]
      vreg_q <= '0;
      ichg_q <= '0;
      flg_q <= '0;
      vin_ok_q <= 1'b0;
      irq_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tmr_q <= tmr_d;
      op_q <= op_d;
      term_q <= term_d;
      lowchg_q <= lowchg_d;
      ilim_q <= ilim_d;
      vreg_q <= vreg_d;
      ichg_q <= ichg_d;
      flg_q <= flg_d;
      vin_ok_q <= vin_ok;
      irq_q <= irq_d;
      fault_q <= fault_d;
    end
  end

  // ==========================================================
  // outputs
  logic sync_q, sync_d;
  always_comb begin
    sync_d = ls_high && (st_q == ccs_pkg::ST_PRECHG ||
                         st_q == ccs_pkg::ST_FAST); // see [R15]
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign operation_select = op_q;
  assign termination_enable = term_q;
  assign low_charge_limit_bit = lowchg_q;
  assign input_current_limit = ilim_q;
  assign regulation_voltage = vreg_q;
  assign fast_charge_current = ichg_q;
  assign second_fault_flag_register = flg_q;
  assign irq_pulse = irq_q;
  assign qual_sink_on = (st_q == ccs_pkg::ST_QUAL); // see [R1] [R4]
  assign short_circuit_current = (st_q == ccs_pkg::ST_PRECHG); // see [R6]
  assign fast_charging = (st_q == ccs_pkg::ST_FAST);
  assign charging = (st_q == ccs_pkg::ST_PRECHG) ||
                    (st_q == ccs_pkg::ST_FAST);
  assign charge_done = (st_q == ccs_pkg::ST_DONE);
  assign high_impedance_state = (st_q == ccs_pkg::ST_HIZ) && !boost_on;
  assign boost_on = (op_q == ccs_pkg::OP_BOOST) && !hot; // see [R10]
  assign low_side_switch_sync = sync_q; // see [R15]
endmodule

// *** ccs_monitor.sv ***
// Purpose: port checker of the sequencer
// Assumes: one clock, reset low
// Notes: bound to every sequencer
module ccs_monitor #(
  parameter int VREG_W = 6
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic op_wr,
  input wire logic cfg_wr,
  input wire logic over_temperature,
  input wire logic [1:0] operation_select,
  input wire logic termination_enable,
  input wire logic [1:0] input_current_limit,
  input wire logic [VREG_W-1:0] regulation_voltage,
  input wire logic [ccs_pkg::FLG_W-1:0] second_fault_flag_register,
  input wire logic irq_pulse,
  input wire logic qual_sink_on,
  input wire logic charging,
  input wire logic high_impedance_state,
  input wire logic boost_on
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ======
  // flag events
  sequence s_bad; $rose(second_fault_flag_register[0]); endsequence
  sequence s_cto; $rose(second_fault_flag_register[1]); endsequence
  sequence s_bto; $rose(second_fault_flag_register[2]); endsequence
  property p_bad; s_bad |-> !qual_sink_on && irq_pulse; endproperty
  a_bad: assert property (p_bad) else $error("sink left on");
  property p_cto; s_cto |-> ##[0:1] irq_pulse; endproperty
  a_cto: assert property (p_cto) else $error("no timeout irq");
  property p_bto; s_bto |-> ##[0:1] operation_select == 2'h0; endproperty
  a_bto: assert property (p_bto) else $error("op kept");
  property p_keep;
    $changed(operation_select) && !$past(op_wr) && !$past(cfg_wr) |->
      operation_select == 2'h0 && $stable(regulation_voltage);
  endproperty
  a_keep: assert property (p_keep) else $error("bad op change");
  property p_rst;
    $rose(nrst) |-> !termination_enable && input_current_limit == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  // pin held four edges covers the two sync stages and the state update
  property p_hiz;
    over_temperature [*4] |->
      high_impedance_state && !charging && !qual_sink_on && !boost_on;
  endproperty
  a_hiz: assert property (p_hiz) else $error("hiz charging");
  property p_boost; boost_on |-> operation_select == 2'h1; endproperty
  a_boost: assert property (p_boost) else $error("stray boost");
  property p_irq; irq_pulse |=> !irq_pulse; endproperty
  a_irq: assert property (p_irq) else $error("long irq");
endmodule

bind ccs_sequencer ccs_monitor #(.VREG_W(VREG_W)) u_mon (
  .clk(clk),
  .nrst(nrst),
  .op_wr(op_wr),
  .cfg_wr(cfg_wr),
  .over_temperature(over_temperature),
  .operation_select(operation_select),
  .termination_enable(termination_enable),
  .input_current_limit(input_current_limit),
  .regulation_voltage(regulation_voltage),
  .second_fault_flag_register(second_fault_flag_register),
  .irq_pulse(irq_pulse),
  .qual_sink_on(qual_sink_on),
  .charging(charging),
  .high_impedance_state(high_impedance_state),
  .boost_on(boost_on)
);

// *** ccs_host_model.sv ***
// Purpose: host model giving register strobes
// Assumes: strobes move at falling edges
// Notes: every strobe is a valid command
module ccs_host_model (
  input wire logic clk,
  output logic i2c_valid_cmd,
  output logic op_wr,
  output logic [1:0] op_wdata,
  output logic cfg_wr,
  output logic term_en_wdata,
  output logic low_charge_limit_bit_wdata,
  output logic [1:0] input_limit_wdata,
  output logic [5:0] vreg_wdata,
  output logic [3:0] ichg_wdata,
  output logic host_reset_bit,
  output logic flag_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {i2c_valid_cmd, op_wr, cfg_wr, host_reset_bit, flag_rd} = 5'h00;
    {op_wdata, term_en_wdata, low_charge_limit_bit_wdata, input_limit_wdata} = 6'h00;
    {vreg_wdata, ichg_wdata} = 10'h000;
  end
  // ======
  // one strobe cycle, then release
  task automatic go;
    i2c_valid_cmd = 1'b1;
    @(negedge clk);
    {i2c_valid_cmd, op_wr, cfg_wr, host_reset_bit, flag_rd} = 5'h00;
  endtask
  task automatic wr_op(input logic [1:0] v);
    @(negedge clk);
    {op_wdata, op_wr} = {v, 1'b1};
    go;
  endtask
  task automatic wr_cfg(input logic t, input logic [1:0] l);
    @(negedge clk);
    term_en_wdata = t;
    {low_charge_limit_bit_wdata, input_limit_wdata} = {1'b0, l};
    {vreg_wdata, ichg_wdata, cfg_wr} = {6'h2A, 4'hA, 1'b1};
    go;
  endtask
  task automatic pulse(input logic rst);
    @(negedge clk);
    {host_reset_bit, flag_rd} = {rst, !rst};
    go;
  endtask
endmodule

// *** ccs_sequencer_tb_top.sv ***
// Purpose: self-checking bench of the sequencer
// Assumes: short timer parameters
// Notes: inputs move at falling edges
module ccs_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QC = 20;
  localparam int RC = 40;
  localparam int BC = 100;
  localparam int CC = 200;
  logic clk = 1'b0, nrst = 1'b0, input_valid = 1'b0;
  logic input_above_min = 1'b0, bat_below_precharge = 1'b0;
  logic bat_below_recharge = 1'b0, at_termination_current = 1'b0;
  logic in_voltage_regulation = 1'b0, over_temperature = 1'b0;
  logic low_side_above_100ma = 1'b0, charge_fault = 1'b0;
  logic i2c_valid_cmd, op_wr, cfg_wr, term_en_wdata, low_charge_limit_bit_wdata;
  logic host_reset_bit, flag_rd, termination_enable, irq_pulse;
  logic low_charge_limit_bit, qual_sink_on, short_circuit_current;
  logic fast_charging, charging, charge_done, high_impedance_state;
  logic boost_on, low_side_switch_sync;
  logic [1:0] op_wdata, input_limit_wdata, operation_select;
  logic [1:0] input_current_limit;
  logic [5:0] vreg_wdata, regulation_voltage;
  logic [3:0] ichg_wdata, fast_charge_current, second_fault_flag_register;
  int errors = 0;
  int num_checks = 0;
  always #2.5 clk = ~clk;
  ccs_sequencer #(
    .QUAL_CYC(QC),
    .RETRY_CYC(RC),
    .BOOST_CYC(BC),
    .CHARGE_CYC(CC)
  ) dut (
    .clk(clk),
    .nrst(nrst),
    .input_valid(input_valid),
    .input_above_min(input_above_min),
    .bat_below_precharge(bat_below_precharge),
    .bat_below_recharge(bat_below_recharge),
    .at_termination_current(at_termination_current),
    .in_voltage_regulation(in_voltage_regulation),
    .over_temperature(over_temperature),
    .low_side_above_100ma(low_side_above_100ma),
    .charge_fault(charge_fault),
    .i2c_valid_cmd(i2c_valid_cmd),
    .op_wr(op_wr),
    .op_wdata(op_wdata),
    .cfg_wr(cfg_wr),
    .term_en_wdata(term_en_wdata),
    .low_charge_limit_bit_wdata(low_charge_limit_bit_wdata),
    .input_limit_wdata(input_limit_wdata),
    .vreg_wdata(vreg_wdata),
    .ichg_wdata(ichg_wdata),
    .host_reset_bit(host_reset_bit),
    .flag_rd(flag_rd),
    .operation_select(operation_select),
    .termination_enable(termination_enable),
    .low_charge_limit_bit(low_charge_limit_bit),
    .input_current_limit(input_current_limit),
    .regulation_voltage(regulation_voltage),
    .fast_charge_current(fast_charge_current),
    .second_fault_flag_register(second_fault_flag_register),
    .irq_pulse(irq_pulse),
    .qual_sink_on(qual_sink_on),
    .short_circuit_current(short_circuit_current),
    .fast_charging(fast_charging),
    .charging(charging),
    .charge_done(charge_done),
    .high_impedance_state(high_impedance_state),
    .boost_on(boost_on),
    .low_side_switch_sync(low_side_switch_sync)
  );
  ccs_host_model h (
    .clk(clk),
    .i2c_valid_cmd(i2c_valid_cmd),
    .op_wr(op_wr),
    .op_wdata(op_wdata),
    .cfg_wr(cfg_wr),
    .term_en_wdata(term_en_wdata),
    .low_charge_limit_bit_wdata(low_charge_limit_bit_wdata),
    .input_limit_wdata(input_limit_wdata),
    .vreg_wdata(vreg_wdata),
    .ichg_wdata(ichg_wdata),
    .host_reset_bit(host_reset_bit),
    .flag_rd(flag_rd)
  );
  // ======
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    tick(3000);
    errors++;
    final_report();
  end
  // ======
  // tests
  initial begin
    tick(10);
    nrst = 1'b1;
    tick(1);
    chk({termination_enable, input_current_limit}, 8'h00);
    {input_valid, input_above_min, bat_below_precharge} = 3'h7;
    bat_below_recharge = 1'b1;
    tick(6);
    chk(low_charge_limit_bit, 8'h01);
    h.wr_op(ccs_pkg::OP_CHG);
    tick(3);
    chk(qual_sink_on, 8'h01);
    tick(QC + 2);
    chk({qual_sink_on, short_circuit_current}, 8'h01);
    {bat_below_precharge, low_side_above_100ma} = 2'h1;
    tick(5);
    chk({fast_charging, low_side_switch_sync}, 8'h03);
    low_side_above_100ma = 1'b0;
    h.wr_cfg(1'b0, 2'h1);
    tick(5);
    chk({low_side_switch_sync, low_charge_limit_bit}, 8'h00);
    chk({input_current_limit, regulation_voltage}, 8'h6A);
    chk(fast_charge_current, 8'h0A);
    $display("charge test done");
    h.wr_op(ccs_pkg::OP_CHG_TERM);
    h.wr_cfg(1'b1, 2'h1);
    chk(termination_enable, 8'h01);
    {in_voltage_regulation, at_termination_current} = 2'h3;
    bat_below_recharge = 1'b0;
    tick(QC + 8);
    chk(charge_done, 8'h01);
    bat_below_recharge = 1'b1;
    tick(5);
    chk(qual_sink_on, 8'h01);
    bat_below_recharge = 1'b0;
    tick(QC + 8);
    h.wr_cfg(1'b0, 2'h1);
    tick(4);
    chk(qual_sink_on, 8'h01);
    tick(QC + 8);
    h.pulse(1'b1);
    tick(4);
    chk(qual_sink_on, 8'h01);
    tick(QC + 8);
    over_temperature = 1'b1;
    tick(5);
    chk({high_impedance_state, charging}, 8'h02);
    over_temperature = 1'b0;
    tick(QC + 8);
    chk(high_impedance_state, 8'h00);
    input_valid = 1'b0;
    tick(5);
    chk({high_impedance_state, charging}, 8'h02);
    input_valid = 1'b1;
    tick(5);
    chk({qual_sink_on, low_charge_limit_bit}, 8'h03);
    $display("restart test done");
    h.pulse(1'b1);
    tick(3);
    input_above_min = 1'b0;
    tick(5);
    chk({qual_sink_on, second_fault_flag_register}, 8'h01);
    input_above_min = 1'b1;
    tick(RC + 4);
    chk(qual_sink_on, 8'h01);
    h.pulse(1'b0);
    chk(second_fault_flag_register, 8'h00);
    tick(QC + 8);
    chk(operation_select, ccs_pkg::OP_CHG_TERM);
    tick(210);
    chk(operation_select, ccs_pkg::OP_OFF);
    chk({second_fault_flag_register, input_current_limit}, 8'h09);
    chk(regulation_voltage, 8'h2A);
    h.wr_op(ccs_pkg::OP_BOOST);
    tick(BC - 20);
    chk(boost_on, 8'h01);
    tick(40);
    chk({boost_on, operation_select}, 8'h00);
    chk(second_fault_flag_register, 8'h06);
    $display("timer test done");
    h.pulse(1'b0);
    h.wr_op(ccs_pkg::OP_CHG);
    tick(QC + 8);
    charge_fault = 1'b1;
    tick(5);
    chk({high_impedance_state, operation_select}, 8'h04);
    chk(second_fault_flag_register, 8'h08);
    $display("fault test done");
    final_report();
  end
endmodule
